/* File: logic/cgss_sequencer.sv */
// clock generation sequencer with oscillator status register on apb
`timescale 1ns/100ps
`include "cgss_defs.svh"

module cgss_sequencer #(
  parameter int unsigned LS_START_CYCLES =
    (`CGSS_LS_START_NS + `CGSS_CLK_PERIOD_NS - 1) / `CGSS_CLK_PERIOD_NS,
  parameter int unsigned HS_START_CYCLES =
    (`CGSS_HS_START_NS + `CGSS_CLK_PERIOD_NS - 1) / `CGSS_CLK_PERIOD_NS,
  parameter int unsigned HS_POR_COUNT    = `CGSS_HS_POR_STAB_COUNT,
  parameter int unsigned LS_STAB_COUNT   = `CGSS_LS_STAB_COUNT,
  parameter int unsigned PLL_STAB_COUNT  = `CGSS_PLL_STAB_COUNT,
  parameter int unsigned PLL_STOP_COUNT  = `CGSS_PLL_STOP_COUNT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_entry,
  input  wire logic        stop_release,
  input  wire logic        xtal_tick,
  input  wire logic        lsrc_tick,
  input  wire logic        hsrc_tick,
  input  wire logic        pll_tick,
  input  wire logic        xtal_failed,
  input  wire logic        pll_failed,
  output logic             xtal_enable,
  output logic             lsrc_enable,
  output logic             hsrc_enable,
  output logic             pll_enable,
  output logic      [9:0]  pll_multiplier,
  output logic             low_speed_clock_on,
  output logic             low_speed_from_xtal,
  output logic             low_speed_backup_active,
  output logic             high_speed_clock_on,
  output logic             high_speed_from_pll,
  output logic             system_clock_select,
  output logic             system_reset_hold,
  output logic             clock_backup_interrupt
);
  import cgss_pkg::*;

  localparam int CW = 24;

  // register state
  logic                 xtal_option;
  logic [1:0]           osc_mode;
  logic                 high_speed_enable;
  logic                 system_clock_select_hs;
  logic                 low_speed_status_flag;
  logic                 high_speed_status_flag;
  logic                 low_speed_backup_cancel;
  logic                 high_speed_backup_cancel;
  logic                 stopped;

  // low-speed sequencing state
  cgss_phase_type       ls_phase;
  logic [CW-1:0]        ls_cnt;
  logic [4:0]           ls_rc_cnt;
  logic                 ls_rc_arm;
  logic                 ls_after_stop;
  logic                 ls_supply;

  // high-speed sequencing state
  cgss_phase_type       hs_phase;
  logic [CW-1:0]        hs_cnt;
  logic [4:0]           hs_rc_cnt;
  logic                 hs_rc_arm;
  logic                 hs_after_stop;
  logic                 hs_por;
  logic                 hs_supply;

  // apb decode
  wire       setup      = psel & ~penable;
  wire       hit_mode   = paddr[31:2] == `CGSS_IDX_MODE;
  wire       hit_fone   = paddr[31:2] == `CGSS_IDX_FCON_ONE;
  wire       hit_fthree = paddr[31:2] == `CGSS_IDX_FCON_THREE;
  wire       hit_status = paddr[31:2] == `CGSS_IDX_STATUS;
  wire       hit_option = paddr[31:2] == `CGSS_IDX_OPTION;
  wire       hit_any    = (hit_mode | hit_fone | hit_fthree | hit_status | hit_option)
                          & (paddr[1:0] == 2'h0);
  wire       wr_do      = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
  wire       wr_mode    = wr_do & hit_mode;
  wire       wr_fone    = wr_do & hit_fone;
  wire       wr_fthree  = wr_do & hit_fthree;
  wire       wr_option  = wr_do & hit_option;
  wire [7:0] wbyte      = pwdata[7:0];

  wire mode_pll   = osc_mode == `CGSS_MODE_PLL;
  wire hs_bk_ok   = xtal_option & mode_pll;
  wire en_rise    = wr_fone & wbyte[`CGSS_ENABLE_BIT] & ~high_speed_enable;
  wire en_fall    = wr_fone & ~wbyte[`CGSS_ENABLE_BIT] & high_speed_enable;
  wire pll_locked = mode_pll & (hs_phase == CGSS_RUN);

  // read mux; the status register has no write path at all
  wire [7:0] rd_status = {5'h00, low_speed_status_flag, high_speed_status_flag, 1'b0};
  wire [7:0] rd_fone   = {pll_locked, 5'h00, high_speed_enable, system_clock_select_hs};
  wire [7:0] rd_fthree = {5'h00, low_speed_backup_cancel, high_speed_backup_cancel, 1'b0};
  wire [7:0] rd_byte   = hit_status ? rd_status :
                         hit_fone   ? rd_fone :
                         hit_fthree ? rd_fthree :
                         hit_mode   ? {6'h00, osc_mode} :
                         hit_option ? {7'h00, xtal_option} : 8'h00;

  // low-speed crystal sequence
  wire ls_start_done = (ls_phase == CGSS_START) & (ls_cnt == CW'(LS_START_CYCLES - 1));
  wire ls_stab_done  = (ls_phase == CGSS_STAB) & xtal_tick
                       & (ls_cnt == CW'(LS_STAB_COUNT - 1));
  wire ls_fail       = xtal_option & (ls_phase == CGSS_RUN) & xtal_failed;
  wire ls_restart    = stop_release & (ls_phase == CGSS_OFF);
  wire ls_irq        = xtal_option & ~stop_entry & (ls_stab_done | ls_fail);
  wire [CW-1:0] next_ls_cnt =
    (stop_entry | ls_fail | ls_start_done | ls_stab_done | ls_restart) ? '0 :
    (ls_phase == CGSS_START) ? ls_cnt + CW'(1) :
    ((ls_phase == CGSS_STAB) & xtal_tick) ? ls_cnt + CW'(1) : ls_cnt;
  cgss_phase_type next_ls_phase;
  assign next_ls_phase =
    stop_entry               ? CGSS_OFF :
    (ls_restart | ls_fail)   ? CGSS_START :
    ls_start_done            ? CGSS_STAB :
    ls_stab_done             ? CGSS_RUN : ls_phase;

  // low-speed rc start count: lsrc for the rc option, hsrc for the divided backup
  wire ls_rc_tick  = xtal_option ? hsrc_tick : lsrc_tick;
  wire ls_rc_done  = ls_rc_arm & ls_rc_tick & (ls_rc_cnt == 5'(`CGSS_RC_STAB_COUNT - 1));
  wire [4:0] next_ls_rc_cnt =
    (stop_entry | stop_release | ls_rc_done) ? 5'h00 :
    (ls_rc_arm & ls_rc_tick) ? ls_rc_cnt + 5'h01 : ls_rc_cnt;
  wire next_ls_rc_arm = stop_entry ? 1'b0 : stop_release ? 1'b1 :
                        ls_rc_done ? 1'b0 : ls_rc_arm;
  wire next_ls_supply =
    stop_entry ? 1'b0 :
    ((ls_rc_done & (~xtal_option | ls_after_stop))
     | (ls_stab_done & xtal_option)) ? 1'b1 : ls_supply;

  wire next_ls_flag =
    stop_entry                  ? 1'b1 :
    ~xtal_option                ? 1'b1 :
    ls_fail                     ? 1'b1 :
    ls_stab_done                ? 1'b0 : low_speed_status_flag;
  // hardware set beats a cancel write in the same cycle
  wire ls_bk_set    = xtal_option & (stop_release | ls_fail);
  wire ls_bk_cancel = wr_fthree & wbyte[`CGSS_LS_CANCEL_BIT];
  wire next_ls_backup =
    ~xtal_option ? 1'b0 :
    ls_bk_set    ? 1'b1 :
    ls_bk_cancel ? 1'b0 : low_speed_backup_cancel;

  // high-speed sequence
  wire hs_tick = (hs_por | ~mode_pll) ? hsrc_tick : pll_tick;
  wire [CW-1:0] hs_target =
    hs_por        ? CW'(HS_POR_COUNT) :
    ~mode_pll     ? CW'(`CGSS_RC_STAB_COUNT) :
    hs_after_stop ? CW'(PLL_STOP_COUNT) : CW'(PLL_STAB_COUNT);
  wire hs_start_done = (hs_phase == CGSS_START) & (hs_cnt == CW'(HS_START_CYCLES - 1));
  wire hs_stab_done  = (hs_phase == CGSS_STAB) & hs_tick & (hs_cnt == hs_target - CW'(1));
  wire hs_fail       = mode_pll & high_speed_enable & (hs_phase == CGSS_RUN) & pll_failed;
  wire hs_restart    = (stop_release & high_speed_enable & (hs_phase == CGSS_OFF)) | en_rise;
  wire hs_halt       = stop_entry | en_fall;
  wire [CW-1:0] next_hs_cnt =
    (hs_halt | hs_restart | hs_fail | hs_start_done | hs_stab_done) ? '0 :
    (hs_phase == CGSS_START) ? hs_cnt + CW'(1) :
    ((hs_phase == CGSS_STAB) & hs_tick) ? hs_cnt + CW'(1) : hs_cnt;
  cgss_phase_type next_hs_phase;
  assign next_hs_phase =
    hs_halt                ? CGSS_OFF :
    (hs_restart | hs_fail) ? CGSS_START :
    hs_start_done          ? CGSS_STAB :
    hs_stab_done           ? CGSS_RUN : hs_phase;

  // rc backup count after release runs beside the pll count
  wire hs_rc_done = hs_rc_arm & hsrc_tick & (hs_rc_cnt == 5'(`CGSS_RC_STAB_COUNT - 1));
  wire [4:0] next_hs_rc_cnt =
    (hs_halt | stop_release | hs_rc_done) ? 5'h00 :
    (hs_rc_arm & hsrc_tick) ? hs_rc_cnt + 5'h01 : hs_rc_cnt;
  wire next_hs_rc_arm = hs_halt ? 1'b0 :
                        (stop_release & high_speed_enable & hs_bk_ok) ? 1'b1 :
                        hs_rc_done ? 1'b0 : hs_rc_arm;
  wire next_hs_supply = hs_halt ? 1'b0 :
                        (hs_stab_done | hs_rc_done) ? 1'b1 : hs_supply;

  wire next_hs_flag =
    ~hs_bk_ok                                  ? high_speed_status_flag :
    stop_entry                                 ? 1'b1 :
    hs_fail                                    ? 1'b1 :
    (~high_speed_enable | en_fall)             ? 1'b0 :
    (hs_stab_done & ~hs_por)                   ? 1'b0 : high_speed_status_flag;
  wire hs_bk_set    = hs_bk_ok & ((stop_release & high_speed_enable) | hs_fail);
  wire hs_bk_cancel = wr_fthree & wbyte[`CGSS_HS_CANCEL_BIT];
  wire next_hs_backup =
    ~hs_bk_ok    ? 1'b0 :
    hs_bk_set    ? 1'b1 :
    hs_bk_cancel ? 1'b0 : high_speed_backup_cancel;

  wire next_enable = wr_fone ? wbyte[`CGSS_ENABLE_BIT] : high_speed_enable;
  // system clock falls back to low speed whenever the high-speed enable bit is cleared; stop entry leaves the select as it is
  wire next_system_clock_select = ~next_enable ? 1'b0 :
                     wr_fone ? wbyte[`CGSS_SYSTEM_CLOCK_SELECT_BIT] : system_clock_select_hs;
  wire next_stopped = stop_entry ? 1'b1 : stop_release ? 1'b0 : stopped;

  // output views
  wire next_xtal_en  = xtal_option & (next_ls_phase != CGSS_OFF);
  wire next_lsrc_en  = ~xtal_option & ~next_stopped;
  wire next_pll_en   = mode_pll & next_enable & ~next_stopped;
  wire next_from_pll = mode_pll & ~next_hs_backup;

  // apb slave: zero wait states, data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      prdata  <= setup ? {24'h00_0000, hit_any ? rd_byte : 8'h00} : prdata;
    end
  end

  // software-owned configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_option       <= `CGSS_OPTION_RESET;
      osc_mode          <= `CGSS_MODE_RESET;
      high_speed_enable <= 1'(`CGSS_FCON_ONE_RESET >> `CGSS_ENABLE_BIT);
      system_clock_select_hs         <= 1'(`CGSS_FCON_ONE_RESET >> `CGSS_SYSTEM_CLOCK_SELECT_BIT);
    end else begin
      xtal_option       <= wr_option ? wbyte[`CGSS_OPTION_BIT] : xtal_option;
      osc_mode          <= wr_mode ? wbyte[1:0] : osc_mode;
      high_speed_enable <= next_enable;
      system_clock_select_hs         <= next_system_clock_select;
    end
  end

  // status flags and backup bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_speed_status_flag    <= 1'(`CGSS_STATUS_RESET >> `CGSS_STATUS_LS_BIT);
      high_speed_status_flag   <= 1'(`CGSS_STATUS_RESET >> `CGSS_STATUS_HS_BIT);
      low_speed_backup_cancel  <= 1'b1;
      high_speed_backup_cancel <= 1'b0;
      stopped                  <= 1'b0;
    end else begin
      low_speed_status_flag    <= next_ls_flag;
      high_speed_status_flag   <= next_hs_flag;
      low_speed_backup_cancel  <= next_ls_backup;
      high_speed_backup_cancel <= next_hs_backup;
      stopped                  <= next_stopped;
    end
  end

  // low-speed sequencer; power-on starts the crystal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_phase      <= CGSS_START;
      ls_cnt        <= '0;
      ls_rc_cnt     <= 5'h00;
      ls_rc_arm     <= 1'b1;
      ls_after_stop <= 1'b0;
      ls_supply     <= 1'b0;
    end else begin
      ls_phase      <= next_ls_phase;
      ls_cnt        <= next_ls_cnt;
      ls_rc_cnt     <= next_ls_rc_cnt;
      ls_rc_arm     <= next_ls_rc_arm;
      ls_after_stop <= stop_release ? 1'b1 : ls_after_stop;
      ls_supply     <= next_ls_supply;
    end
  end

  // high-speed sequencer; power-on runs the rc oscillator under system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_phase      <= CGSS_START;
      hs_cnt        <= '0;
      hs_rc_cnt     <= 5'h00;
      hs_rc_arm     <= 1'b0;
      hs_after_stop <= 1'b0;
      hs_por        <= 1'b1;
      hs_supply     <= 1'b0;
    end else begin
      hs_phase      <= next_hs_phase;
      hs_cnt        <= next_hs_cnt;
      hs_rc_cnt     <= next_hs_rc_cnt;
      hs_rc_arm     <= next_hs_rc_arm;
      hs_after_stop <= stop_release ? 1'b1 : en_rise ? 1'b0 : hs_after_stop;
      hs_por        <= (hs_stab_done | hs_halt) ? 1'b0 : hs_por;
      hs_supply     <= next_hs_supply;
    end
  end

  // outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_enable             <= 1'b0;
      lsrc_enable             <= 1'b0;
      hsrc_enable             <= 1'b0;
      pll_enable              <= 1'b0;
      pll_multiplier          <= 10'h000;
      low_speed_clock_on      <= 1'b0;
      low_speed_from_xtal     <= 1'b0;
      low_speed_backup_active <= 1'b0;
      high_speed_clock_on     <= 1'b0;
      high_speed_from_pll     <= 1'b0;
      system_clock_select     <= 1'b0;
      system_reset_hold       <= 1'b1;
      clock_backup_interrupt  <= 1'b0;
    end else begin
      xtal_enable             <= next_xtal_en;
      lsrc_enable             <= next_lsrc_en;
      hsrc_enable             <= ~next_stopped;
      pll_enable              <= next_pll_en;
      pll_multiplier          <= `CGSS_PLL_MULT;
      low_speed_clock_on      <= next_ls_supply;
      low_speed_from_xtal     <= xtal_option & ~next_ls_backup;
      low_speed_backup_active <= next_ls_backup;
      high_speed_clock_on     <= next_hs_supply;
      high_speed_from_pll     <= next_from_pll;
      system_clock_select     <= next_system_clock_select;
      system_reset_hold       <= hs_por & ~hs_stab_done;
      clock_backup_interrupt  <= ls_irq;
    end
  end

endmodule

/* File: logic/cgss_defs.svh */
// constants of the clock generation status sequencer
`ifndef CGSS_DEFS_SVH
`define CGSS_DEFS_SVH

`define CGSS_CLK_PERIOD_NS      20
`define CGSS_LS_START_NS        2000000
`define CGSS_HS_START_NS        1000

`define CGSS_LS_STAB_COUNT      8192
`define CGSS_RC_STAB_COUNT      16
`define CGSS_HS_POR_STAB_COUNT  32768
`define CGSS_PLL_STAB_COUNT     8192
`define CGSS_PLL_STOP_COUNT     4096
`define CGSS_PLL_MULT           10'h1f4

`define CGSS_IDX_MODE           30'h0000f002
`define CGSS_IDX_FCON_ONE       30'h0000f003
`define CGSS_IDX_FCON_THREE     30'h0000f005
`define CGSS_IDX_STATUS         30'h0000f00a
`define CGSS_IDX_OPTION         30'h0000f00f

`define CGSS_STATUS_RESET       8'h06
`define CGSS_STATUS_LS_BIT      2
`define CGSS_STATUS_HS_BIT      1
`define CGSS_FCON_ONE_RESET     8'h03
`define CGSS_LOCK_BIT           7
`define CGSS_ENABLE_BIT         1
`define CGSS_SYSTEM_CLOCK_SELECT_BIT         0
`define CGSS_LS_CANCEL_BIT      2
`define CGSS_HS_CANCEL_BIT      1
`define CGSS_MODE_RESET         2'h0
`define CGSS_MODE_PLL           2'h2
`define CGSS_OPTION_BIT         0
`define CGSS_OPTION_RESET       1'h1

`endif

/* File: logic/cgss_pkg.sv */
// types of the clock generation status sequencer
package cgss_pkg;
  typedef enum logic [1:0] {
    CGSS_OFF   = 2'b00,
    CGSS_START = 2'b01,
    CGSS_STAB  = 2'b10,
    CGSS_RUN   = 2'b11
  } cgss_phase_type;
endpackage

/* File: tb/cgss_osc_model.sv */
// oscillator model standing behind the sequencer's enable and tick pins
`timescale 1ns/100ps
module cgss_osc_model (
  input  wire logic pclk,
  input  wire logic xtal_enable,
  input  wire logic lsrc_enable,
  input  wire logic hsrc_enable,
  input  wire logic pll_enable,
  input  wire logic pll_stop,
  output logic      xtal_tick,
  output logic      lsrc_tick,
  output logic      hsrc_tick,
  output logic      pll_tick,
  output logic      xtal_failed,
  output logic      pll_failed
);
  logic [1:0] div = 2'h0;

  always @(posedge pclk) begin
    div <= div + 2'h1;
  end
  // slow sources tick only on some cycles, so counts never line up with pclk
  assign xtal_tick   = xtal_enable & ~div[0];
  assign lsrc_tick   = lsrc_enable & (div == 2'h3);
  assign hsrc_tick   = hsrc_enable;
  assign pll_tick    = pll_enable & ~pll_stop;
  assign pll_failed  = pll_enable & pll_stop;
  assign xtal_failed = 1'b0;
endmodule

/* File: tb/cgss_checker.sv */
// port checker of the clock generation status sequencer
`timescale 1ns/100ps
module cgss_checker #(
  parameter int unsigned LS_STAB_COUNT = 8192
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        stop_entry,
  input wire logic        stop_release,
  input wire logic        xtal_tick,
  input wire logic [9:0]  pll_multiplier,
  input wire logic        low_speed_clock_on,
  input wire logic        low_speed_from_xtal,
  input wire logic        high_speed_clock_on,
  input wire logic        system_reset_hold,
  input wire logic        clock_backup_interrupt
);
  logic [15:0] xt_cnt;
  logic        rel_seen;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // saturating, so a long run cannot wrap back under the stabilisation count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xt_cnt   <= 16'h0000;
      rel_seen <= 1'b0;
    end else begin
      if (xtal_tick && xt_cnt != 16'hffff) begin
        xt_cnt <= xt_cnt + 16'h0001;
      end
      if (stop_release) begin
        rel_seen <= 1'b1;
      end
    end
  end

  a_status_rsvd : assert property (
    psel && penable && pready && !pwrite && paddr == 32'h0003c028 |-> prdata[31:3] == 29'h0
    && !prdata[0]) else $error("status read shows a reserved bit");
  a_stop_quiet : assert property (
    stop_entry |-> ##1 !clock_backup_interrupt [*2]) else $error("interrupt after stop entry");
  a_irq_pulse : assert property (
    clock_backup_interrupt |=> !clock_backup_interrupt) else $error("interrupt longer than a cycle");
  a_stop_halt : assert property (
    stop_entry |=> !low_speed_clock_on && !high_speed_clock_on) else $error("clock runs in stop");
  a_release_rc : assert property (
    stop_release |=> !low_speed_from_xtal) else $error("crystal source right after release");
  a_pll_ratio : assert property (
    $past(presetn) |-> pll_multiplier == 10'h1f4) else $error("pll multiplier wrong");
  a_por_join : assert property (
    $fell(system_reset_hold) |-> $rose(high_speed_clock_on)) else $error("hs clock not with reset end");
  a_hold_noclk : assert property (
    system_reset_hold |-> !high_speed_clock_on) else $error("hs clock during system reset");
  a_ls_count : assert property (
    $rose(low_speed_clock_on) && !rel_seen |-> xt_cnt >= LS_STAB_COUNT)
    else $error("low-speed clock before crystal count");

  cover property ($rose(clock_backup_interrupt));
  cover property ($fell(system_reset_hold));
  cover property (stop_entry ##[1:200] stop_release);
endmodule

bind cgss_sequencer cgss_checker #(.LS_STAB_COUNT(LS_STAB_COUNT)) chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .stop_entry,
  .stop_release, .xtal_tick, .pll_multiplier, .low_speed_clock_on, .low_speed_from_xtal,
  .high_speed_clock_on, .system_reset_hold, .clock_backup_interrupt
);

/* File: tb/tb_top.sv */
// self-checking bench of the clock generation status sequencer
`timescale 1ns/100ps
module tb_top;
  localparam logic [31:0] ST = 32'h0003c028;
  localparam logic [31:0] F1 = 32'h0003c00c;
  localparam logic [31:0] F3 = 32'h0003c014;
  localparam logic [31:0] MD = 32'h0003c008;
  typedef struct packed {logic w; logic [31:0] a; logic [7:0] d; logic [7:0] e; logic err;}
    cgss_row_type;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, stop_entry, stop_release;
  logic        xtal_tick, lsrc_tick, hsrc_tick, pll_tick, xtal_failed, pll_failed, pll_stop;
  logic        xtal_enable, lsrc_enable, hsrc_enable, pll_enable, low_speed_clock_on;
  logic        low_speed_from_xtal, low_speed_backup_active, high_speed_clock_on;
  logic        high_speed_from_pll, system_clock_select, system_reset_hold, clock_backup_interrupt;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [9:0]  pll_multiplier;
  logic [7:0]  r;
  logic        e;
  int          miscompares, compares, cycles, irqs, k, n;
  cgss_row_type rows [11] = '{'{0, ST, 0, 8'h06, 0}, '{1, ST, 0, 0, 0}, '{0, ST, 0, 8'h06, 0},
    '{0, F1, 0, 8'h03, 0}, '{0, F3, 0, 8'h04, 0}, '{1, F3, 0, 0, 0}, '{0, F3, 0, 8'h04, 0},
    '{0, MD, 0, 8'h00, 0}, '{0, 32'h0003c03c, 0, 8'h01, 0}, '{0, 32'h0003c010, 0, 0, 1},
    '{0, 32'h0003c029, 0, 0, 1}};

  cgss_sequencer #(.LS_START_CYCLES(40), .HS_START_CYCLES(4), .HS_POR_COUNT(8),
    .LS_STAB_COUNT(16), .PLL_STAB_COUNT(16), .PLL_STOP_COUNT(8)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .stop_entry, .stop_release, .xtal_tick, .lsrc_tick, .hsrc_tick, .pll_tick,
    .xtal_failed, .pll_failed, .xtal_enable, .lsrc_enable, .hsrc_enable, .pll_enable,
    .pll_multiplier, .low_speed_clock_on, .low_speed_from_xtal, .low_speed_backup_active,
    .high_speed_clock_on, .high_speed_from_pll, .system_clock_select, .system_reset_hold,
    .clock_backup_interrupt);
  cgss_osc_model osc (.pclk, .xtal_enable, .lsrc_enable, .hsrc_enable, .pll_enable, .pll_stop,
    .xtal_tick, .lsrc_tick, .hsrc_tick, .pll_tick, .xtal_failed, .pll_failed);

  task automatic print_verdict;
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  // holds the whole request until pready is seen high at a rising edge, or for at most 50 cycles
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk($sformatf("read %h", a), r, x);
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (clock_backup_interrupt === 1'b1) irqs++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stop_entry, stop_release, pll_stop} = '0;
    pstrb = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row data", r, rows[i].e);
      chk("row error", e, rows[i].err);
    end
    // a write with its low byte lane masked must leave the register alone
    pstrb <= 4'h0;
    apb(1'b1, F1, 8'h00);
    pstrb <= 4'hf;
    rd(F1, 8'h03);
    for (n = 0; n < 2000 && system_reset_hold !== 1'b0; n++) @(posedge pclk);
    chk("hs clock at por", high_speed_clock_on, 1);
    for (n = 0; n < 2000 && low_speed_clock_on !== 1'b1; n++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    rd(ST, 8'h02);
    apb(1'b1, F3, 8'h04);
    @(posedge pclk);
    chk("ls from crystal", low_speed_from_xtal, 1);
    rd(F3, 8'h00);
    k = irqs;
    stop_entry <= 1'b1;
    @(posedge pclk);
    stop_entry <= 1'b0;
    rd(ST, 8'h06);
    chk("ls off in stop", low_speed_clock_on, 0);
    chk("no irq at stop", irqs, k);
    stop_release <= 1'b1;
    @(posedge pclk);
    stop_release <= 1'b0;
    for (n = 0; n < 2000 && low_speed_clock_on !== 1'b1; n++) @(posedge pclk);
    chk("ls from rc", low_speed_from_xtal, 0);
    rd(F3, 8'h04);
    for (n = 0; n < 2000 && irqs == k; n++) @(posedge pclk);
    chk("one backup irq", irqs, k + 1);
    repeat (2) @(posedge pclk);
    rd(ST, 8'h02);
    apb(1'b1, F3, 8'h04);
    apb(1'b1, F1, 8'h00);
    apb(1'b1, MD, 8'h02);
    apb(1'b1, F1, 8'h03);
    chk("hs off while counting", high_speed_clock_on, 0);
    for (n = 0; n < 2000 && high_speed_clock_on !== 1'b1; n++) @(posedge pclk);
    chk("hs from pll", high_speed_from_pll, 1);
    rd(ST, 8'h00);
    pll_stop <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ST, 8'h02);
    rd(F3, 8'h02);
    chk("hs backup on rc", high_speed_from_pll, 0);
    pll_stop <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b1, F3, 8'h02);
    @(posedge pclk);
    chk("hs back to pll", high_speed_from_pll, 1);
    rd(F3, 8'h00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ST, 8'h06);
    print_verdict;
  end
endmodule
